// *** shared/pot_cmd_pkg.sv ***
// Contract
// (RULE_01) Opcode 1100 with selectors and data byte writes a slot; nonvolatile write follows.
// (RULE_02) Opcode 1101 copies chosen slot of chosen pot into that pot's wiper counter.
// (RULE_03) Opcode 1110 copies pot's wiper counter into chosen slot; nonvolatile write follows.
// (RULE_04) Opcode 0010 then pot selector; every later bit steps that wiper until deselect.
// (RULE_05) Opcode 0001 loads every wiper counter from its own chosen slot, no data byte.
// (RULE_06) Opcode 1000 stores all wiper counters in chosen slots; nonvolatile write follows.
// (RULE_07) Status command 0101 0001 returns seven zeros then the write-busy flag.
// (RULE_08) Frame header must be 0101, two zeros, then the two address pins' values.
// (RULE_09) While stepping, serial input high means increment, low means decrement.
// (RULE_10) Bad identifier, address or opcode is ignored; stepping saturates at both ends.
package pot_cmd_pkg;
  localparam int CLK_FREQ_HZ = 50_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;
  localparam int NV_WRITE_TIME_NS = 10_000;
  localparam int NV_WRITE_CYCLES = NV_WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int TIMER_W = 16;
  localparam logic [TIMER_W-1:0] NV_WRITE_LOAD = TIMER_W'(NV_WRITE_CYCLES);
  localparam logic [3:0] DEV_TYPE = 4'h5;
  localparam logic [1:0] HDR_ZERO = 2'h0;
  localparam logic [3:0] OP_RD_WIPER = 4'h9;
  localparam logic [3:0] OP_WR_WIPER = 4'hA;
  localparam logic [3:0] OP_RD_SLOT = 4'hB;
  localparam logic [3:0] OP_WR_SLOT = 4'hC;
  localparam logic [3:0] OP_SLOT_TO_WIPER = 4'hD;
  localparam logic [3:0] OP_WIPER_TO_SLOT = 4'hE;
  localparam logic [3:0] OP_ALL_SLOT_TO_WIPER = 4'h1;
  localparam logic [3:0] OP_ALL_WIPER_TO_SLOT = 4'h8;
  localparam logic [3:0] OP_STEP = 4'h2;
  localparam logic [3:0] OP_STATUS = 4'h5;
  localparam logic [3:0] STATUS_LOW = 4'h1;
  localparam logic [4:0] HDR_LAST = 5'h07;
  localparam logic [4:0] INSTR_LAST = 5'h0F;
  localparam logic [4:0] DATA_LAST = 5'h17;
  localparam logic [4:0] BITS_INSTR = 5'h10;
  localparam logic [4:0] BITS_FRAME = 5'h18;
  localparam logic [7:0] WIPER_MAX = 8'hFF;
  localparam logic [7:0] WIPER_MIN = 8'h00;
  localparam logic [7:0] WIPER_RESET = 8'h00;
  localparam logic [6:0] STATUS_PAD = 7'h00;
  localparam logic [1:0] LAST_POT = 2'h3;
  localparam logic [4:0] SYNC_RESET = 5'h10;
  typedef struct packed {
    logic [3:0] opcode;
    logic [1:0] slot;
    logic [1:0] pot;
  } instr_s;
  typedef logic [3:0][7:0] wiper_bank_t;
  typedef enum logic [1:0] {EX_IDLE = 2'b00, EX_ISSUE = 2'b01, EX_APPLY = 2'b11} exec_e;
endpackage : pot_cmd_pkg

// *** verilog/slot_store.sv ***
`timescale 1ns/1ps
module slot_store #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 8,
  parameter int AW = 4
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [WIDTH-1:0] o_rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      o_rdata <= '0;
    end else begin
      if (i_we) begin
        mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
    end
  end
endmodule : slot_store

// *** verilog/quad_pot_spi_command_decoder.sv ***
`timescale 1ns/1ps
module quad_pot_spi_command_decoder (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic I_CS_N,
  input wire logic I_SCK,
  input wire logic I_SI,
  input wire logic I_CHIP_SELECT_BIT_HI,
  input wire logic I_CHIP_SELECT_BIT_LO,
  output logic O_SO,
  output logic O_SO_OE_N,
  output pot_cmd_pkg::wiper_bank_t O_WIPER,
  output logic O_WRITE_BUSY
);
  import pot_cmd_pkg::*;

  // ****************
  // Pin synchronisers
  // ****************
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic sck_d;
  logic cs_d;
  logic cs_n_s;
  logic sck_s;
  logic si_s;
  logic [1:0] addr_s;

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      sync1 <= SYNC_RESET;
      sync2 <= SYNC_RESET;
      sck_d <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      sync1 <= {I_CS_N, I_SCK, I_SI, I_CHIP_SELECT_BIT_HI, I_CHIP_SELECT_BIT_LO};
      sync2 <= sync1;
      sck_d <= sync2[3];
      cs_d <= sync2[4];
    end
  end

  assign cs_n_s = sync2[4];
  assign sck_s = sync2[3];
  assign si_s = sync2[2];
  assign addr_s = sync2[1:0];

  // ****************
  // Frame receiver
  // ****************
  logic rise;
  logic fall;
  logic cs_rise;
  logic cs_fall;
  logic [7:0] byte_in;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic [7:0] shreg, next_shreg;
  logic hdr_ok, next_hdr_ok;
  instr_s instr, next_instr;
  logic instr_valid, next_instr_valid;
  logic [7:0] data_byte, next_data_byte;
  logic data_valid, next_data_valid;
  logic [7:0] tx, next_tx;
  logic so, next_so;
  logic so_oe_n, next_so_oe_n;
  logic rd_pend, next_rd_pend;
  logic step_req;
  logic wiper_load;
  logic exec_go;
  logic busy;
  logic [7:0] mem_rdata;
  wiper_bank_t wiper;

  function automatic logic legal(input instr_s c);
    case (c.opcode)
      OP_RD_WIPER, OP_WR_WIPER: legal = (c.slot == 2'h0);
      OP_RD_SLOT, OP_WR_SLOT, OP_SLOT_TO_WIPER, OP_WIPER_TO_SLOT, OP_STEP: legal = 1'b1;
      OP_ALL_SLOT_TO_WIPER, OP_ALL_WIPER_TO_SLOT: legal = (c.pot == 2'h0);
      OP_STATUS: legal = ({c.slot, c.pot} == STATUS_LOW);
      default: legal = 1'b0;
    endcase
  endfunction : legal

  assign rise = sck_s & ~sck_d & ~cs_n_s;
  assign fall = ~sck_s & sck_d & ~cs_n_s;
  assign cs_rise = cs_n_s & ~cs_d;
  assign cs_fall = ~cs_n_s & cs_d;
  assign byte_in = {shreg[6:0], si_s};
  assign step_req = rise && instr_valid && instr.opcode == OP_STEP
    && bit_cnt >= BITS_INSTR; // see (RULE_04)
  assign wiper_load = rise && instr_valid && instr.opcode == OP_WR_WIPER && bit_cnt == DATA_LAST;
  assign exec_go = cs_rise && instr_valid && bit_cnt >= BITS_INSTR
    && (instr.opcode == OP_SLOT_TO_WIPER || instr.opcode == OP_ALL_SLOT_TO_WIPER
    || (!busy && (instr.opcode == OP_WIPER_TO_SLOT || instr.opcode == OP_ALL_WIPER_TO_SLOT))
    || (!busy && instr.opcode == OP_WR_SLOT && data_valid));

  always_comb begin
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_hdr_ok = hdr_ok;
    next_instr = instr;
    next_instr_valid = instr_valid;
    next_data_byte = data_byte;
    next_data_valid = data_valid;
    next_tx = tx;
    next_so = so;
    next_so_oe_n = so_oe_n;
    next_rd_pend = 1'b0;
    if (cs_fall) begin
      next_bit_cnt = 5'h00;
      next_hdr_ok = 1'b0;
      next_instr_valid = 1'b0;
      next_data_valid = 1'b0;
    end
    if (rise) begin
      next_shreg = byte_in;
      if (bit_cnt != BITS_FRAME) begin
        next_bit_cnt = bit_cnt + 5'h01;
      end
      if (bit_cnt == HDR_LAST) begin
        next_hdr_ok = (byte_in == {DEV_TYPE, HDR_ZERO, addr_s}); // see (RULE_08)
      end
      if (bit_cnt == INSTR_LAST) begin
        next_instr = instr_s'(byte_in);
        next_instr_valid = hdr_ok && legal(instr_s'(byte_in)); // see (RULE_10)
        next_rd_pend = hdr_ok && legal(instr_s'(byte_in)) && (byte_in[7:4] == OP_RD_WIPER
          || byte_in[7:4] == OP_RD_SLOT || byte_in[7:4] == OP_STATUS);
      end
      if (bit_cnt == DATA_LAST && instr_valid) begin
        next_data_byte = byte_in;
        next_data_valid = 1'b1;
      end
    end
    if (rd_pend) begin
      case (instr.opcode)
        OP_RD_WIPER: next_tx = wiper[instr.pot];
        OP_RD_SLOT: next_tx = mem_rdata;
        default: next_tx = {STATUS_PAD, busy}; // see (RULE_07)
      endcase
    end
    if (fall && instr_valid && bit_cnt >= BITS_INSTR) begin
      next_so = tx[7];
      next_tx = {tx[6:0], 1'b0};
      next_so_oe_n = !(instr.opcode == OP_RD_WIPER || instr.opcode == OP_RD_SLOT
        || instr.opcode == OP_STATUS);
    end
    if (cs_n_s) begin
      next_so_oe_n = 1'b1;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      bit_cnt <= 5'h00;
      shreg <= 8'h00;
      hdr_ok <= 1'b0;
      instr <= '0;
      instr_valid <= 1'b0;
      data_byte <= 8'h00;
      data_valid <= 1'b0;
      tx <= 8'h00;
      so <= 1'b0;
      so_oe_n <= 1'b1;
      rd_pend <= 1'b0;
    end else begin
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      hdr_ok <= next_hdr_ok;
      instr <= next_instr;
      instr_valid <= next_instr_valid;
      data_byte <= next_data_byte;
      data_valid <= next_data_valid;
      tx <= next_tx;
      so <= next_so;
      so_oe_n <= next_so_oe_n;
      rd_pend <= next_rd_pend;
    end
  end

  // ****************
  // Command executor and wipers
  // ****************
  exec_e ex_state, next_ex_state;
  logic [1:0] ex_idx, next_ex_idx;
  logic [1:0] ex_last, next_ex_last;
  logic [3:0] ex_op, next_ex_op;
  logic [1:0] ex_slot, next_ex_slot;
  logic [7:0] ex_data, next_ex_data;
  logic [TIMER_W-1:0] timer, next_timer;
  logic next_busy;
  wiper_bank_t next_wiper;
  logic mem_we;
  logic [3:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [3:0] mem_raddr;
  logic global_op;

  assign global_op = instr.opcode == OP_ALL_SLOT_TO_WIPER || instr.opcode == OP_ALL_WIPER_TO_SLOT;

  always_comb begin
    next_ex_state = ex_state;
    next_ex_idx = ex_idx;
    next_ex_last = ex_last;
    next_ex_op = ex_op;
    next_ex_slot = ex_slot;
    next_ex_data = ex_data;
    next_wiper = wiper;
    next_timer = (timer != '0) ? timer - 1'b1 : timer;
    mem_we = 1'b0;
    mem_waddr = {ex_idx, ex_slot};
    mem_wdata = ex_data;
    mem_raddr = (ex_state == EX_IDLE) ? {byte_in[1:0], byte_in[3:2]} : {ex_idx, ex_slot};
    case (ex_state)
      EX_IDLE: begin
        if (exec_go) begin
          next_ex_state = EX_ISSUE;
          next_ex_op = instr.opcode;
          next_ex_slot = instr.slot;
          next_ex_data = data_byte;
          next_ex_idx = global_op ? 2'h0 : instr.pot; // see (RULE_05)
          next_ex_last = global_op ? LAST_POT : instr.pot; // see (RULE_06)
          if (instr.opcode == OP_WR_SLOT || instr.opcode == OP_WIPER_TO_SLOT
              || instr.opcode == OP_ALL_WIPER_TO_SLOT) begin
            next_timer = NV_WRITE_LOAD; // see (RULE_01) see (RULE_03) see (RULE_06)
          end
        end
      end
      EX_ISSUE: begin
        next_ex_state = EX_APPLY;
        if (ex_op == OP_WR_SLOT) begin
          mem_we = 1'b1; // see (RULE_01)
        end else if (ex_op == OP_WIPER_TO_SLOT || ex_op == OP_ALL_WIPER_TO_SLOT) begin
          mem_we = 1'b1; // see (RULE_03) see (RULE_06)
          mem_wdata = wiper[ex_idx];
        end
      end
      EX_APPLY: begin
        if (ex_op == OP_SLOT_TO_WIPER || ex_op == OP_ALL_SLOT_TO_WIPER) begin
          next_wiper[ex_idx] = mem_rdata; // see (RULE_02) see (RULE_05)
        end
        if (ex_idx == ex_last) begin
          next_ex_state = EX_IDLE;
        end else begin
          next_ex_idx = ex_idx + 2'h1;
          next_ex_state = EX_ISSUE;
        end
      end
      default: next_ex_state = EX_IDLE;
    endcase
    if (wiper_load) begin
      next_wiper[instr.pot] = byte_in;
    end
    if (step_req) begin
      if (si_s && wiper[instr.pot] != WIPER_MAX) begin
        next_wiper[instr.pot] = wiper[instr.pot] + 8'h01; // see (RULE_09) see (RULE_10)
      end else if (!si_s && wiper[instr.pot] != WIPER_MIN) begin
        next_wiper[instr.pot] = wiper[instr.pot] - 8'h01; // see (RULE_09) see (RULE_10)
      end
    end
    next_busy = (next_timer != '0);
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      ex_state <= EX_IDLE;
      ex_idx <= 2'h0;
      ex_last <= 2'h0;
      ex_op <= 4'h0;
      ex_slot <= 2'h0;
      ex_data <= 8'h00;
      timer <= '0;
      busy <= 1'b0;
      wiper <= {4{WIPER_RESET}};
    end else begin
      ex_state <= next_ex_state;
      ex_idx <= next_ex_idx;
      ex_last <= next_ex_last;
      ex_op <= next_ex_op;
      ex_slot <= next_ex_slot;
      ex_data <= next_ex_data;
      timer <= next_timer;
      busy <= next_busy;
      wiper <= next_wiper;
    end
  end

  slot_store #(.DEPTH(16), .WIDTH(8), .AW(4)) u_slots (
    .i_clock(I_CLOCK),
    .i_rst(I_RST),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(mem_wdata),
    .i_raddr(mem_raddr),
    .o_rdata(mem_rdata)
  );

  assign O_SO = so;
  assign O_SO_OE_N = so_oe_n;
  assign O_WIPER = wiper;
  assign O_WRITE_BUSY = busy;

  // ****************
  // Checks
  // ****************
  AST_WR_SLOT: assert property (@(posedge I_CLOCK) disable iff (I_RST) // see (RULE_01)
    ex_state == EX_ISSUE && ex_op == OP_WR_SLOT |-> mem_we && mem_wdata == ex_data && busy)
    else $error("slot write did not store the data byte");
  AST_SLOT_TO_WIPER: assert property (@(posedge I_CLOCK) disable iff (I_RST) // see (RULE_02)
    ex_state == EX_APPLY && ex_op == OP_SLOT_TO_WIPER |=> wiper[$past(ex_idx)] == $past(mem_rdata))
    else $error("slot to wiper copy lost");
  AST_WIPER_TO_SLOT: assert property (@(posedge I_CLOCK) disable iff (I_RST) // see (RULE_03)
    ex_state == EX_ISSUE && ex_op == OP_WIPER_TO_SLOT
    |-> mem_we && mem_wdata == wiper[ex_idx] && mem_waddr == {ex_idx, ex_slot})
    else $error("wiper to slot copy wrong");
  AST_STEP_UP: assert property (@(posedge I_CLOCK) disable iff (I_RST) // see (RULE_04)
    step_req && si_s && wiper[instr.pot] != WIPER_MAX && !wiper_load
    |=> wiper[$past(instr.pot)] == $past(wiper[instr.pot]) + 8'h01)
    else $error("increment step missed");
  AST_STEP_DOWN: assert property (@(posedge I_CLOCK) disable iff (I_RST) // see (RULE_09)
    step_req && !si_s && wiper[instr.pot] != WIPER_MIN
    |=> wiper[$past(instr.pot)] == $past(wiper[instr.pot]) - 8'h01)
    else $error("decrement step missed");
  AST_GLOBAL_WALK: assert property (@(posedge I_CLOCK) disable iff (I_RST) // see (RULE_05)
    ex_state == EX_IDLE && exec_go && instr.opcode == OP_ALL_SLOT_TO_WIPER
    |=> ex_idx == 2'h0 ##7 ex_state == EX_APPLY && ex_idx == LAST_POT ##1 ex_state == EX_IDLE)
    else $error("global recall did not visit four pots");
  AST_GLOBAL_STORE_BUSY: assert property (@(posedge I_CLOCK) disable iff (I_RST) // see (RULE_06)
    ex_state == EX_IDLE && exec_go && instr.opcode == OP_ALL_WIPER_TO_SLOT
    |=> ##1 busy [*8])
    else $error("global store did not raise write busy");
  AST_STATUS_BYTE: assert property (@(posedge I_CLOCK) disable iff (I_RST) // see (RULE_07)
    rd_pend && instr.opcode == OP_STATUS |=> tx == {STATUS_PAD, $past(busy)})
    else $error("status byte malformed");
  AST_BAD_HEADER: assert property (@(posedge I_CLOCK) disable iff (I_RST) // see (RULE_08)
    rise && bit_cnt == HDR_LAST && byte_in != {DEV_TYPE, HDR_ZERO, addr_s} |=> !hdr_ok)
    else $error("foreign header accepted");
  AST_SATURATE: assert property (@(posedge I_CLOCK) disable iff (I_RST) // see (RULE_10)
    step_req && si_s && wiper[instr.pot] == WIPER_MAX |=> wiper[$past(instr.pot)] == WIPER_MAX)
    else $error("wiper wrapped past top");
endmodule : quad_pot_spi_command_decoder

// *** dv/spi_master_model.sv ***
`timescale 1ns/1ps
// ****
// SPI master model
// ****
module spi_master_model (
  input wire logic i_clock,
  input wire logic i_so,
  output logic o_cs_n,
  output logic o_sck,
  output logic o_si
);
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
  end
  // Sends n bits MSB first, four clocks per phase; rd keeps the last eight bits
  task automatic xfer(input logic [23:0] b, input int n, output logic [7:0] rd);
    rd = 8'h00;
    @(negedge i_clock) o_cs_n = 1'b0;
    repeat (4) @(negedge i_clock);
    for (int i = n - 1; i >= 0; i--) begin
      o_sck = 1'b0;
      o_si = b[i];
      repeat (4) @(negedge i_clock);
      o_sck = 1'b1;
      repeat (4) @(negedge i_clock);
      rd = {rd[6:0], i_so};
    end
    o_sck = 1'b0;
    repeat (4) @(negedge i_clock);
    o_cs_n = 1'b1;
    o_si = ~o_si;
    repeat (16) @(negedge i_clock);
  endtask : xfer
endmodule : spi_master_model

// *** dv/quad_pot_spi_command_decoder_tb_top.sv ***
`timescale 1ns/1ps
// ****
// Testbench
// ****
module quad_pot_spi_command_decoder_tb_top;
  import pot_cmd_pkg::*;
  logic clock, rst, cs_n, sck, si, so, so_oe_n, busy;
  logic [1:0] addr, p, r;
  logic [7:0] rd, d, hd;
  wiper_bank_t wiper;
  int bad_count, total_checks, seed, wip[4], slt[16];
  logic oe_low = 1'b0;
  logic cs_was = 1'b1;

  // Remembers whether the output enable went low since the last chip select fall
  always @(negedge clock) begin
    cs_was <= cs_n;
    if (so_oe_n === 1'b0) begin
      oe_low <= 1'b1;
    end else if (cs_was === 1'b1 && cs_n === 1'b0) begin
      oe_low <= 1'b0;
    end
  end

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  spi_master_model i_spi_master_model (.i_clock(clock), .i_so(so), .o_cs_n(cs_n),
    .o_sck(sck), .o_si(si));
  quad_pot_spi_command_decoder i_quad_pot_spi_command_decoder (.I_CLOCK(clock),
    .I_RST(rst), .I_CS_N(cs_n), .I_SCK(sck), .I_SI(si), .I_CHIP_SELECT_BIT_HI(addr[1]),
    .I_CHIP_SELECT_BIT_LO(addr[0]), .O_SO(so), .O_SO_OE_N(so_oe_n), .O_WIPER(wiper),
    .O_WRITE_BUSY(busy));

  task automatic print_verdict;
    if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic chk_wipers;
    for (int i = 0; i < 4; i++) chk("wiper", wip[i][7:0], wiper[i]);
  endtask : chk_wipers

  task automatic send(input logic [7:0] h, input logic [3:0] op, input logic [1:0] s,
      input logic [1:0] q, input logic [7:0] t, input int n);
    i_spi_master_model.xfer({h, op, s, q, t} >> (24 - n), n, rd);
  endtask : send

  task automatic wait_idle;
    for (int i = 0; i < 600 && busy !== 1'b0; i++) @(negedge clock);
    chk("busy", 8'h00, {7'h00, busy});
  endtask : wait_idle

  task automatic set_all;
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      send(hd, 4'hA, 2'h0, 2'(i), d, 24);
      chk("oe_low", 8'h00, {7'h00, oe_low});
      wip[i] = d;
      send(hd, 4'h9, 2'h0, 2'(i), 8'h00, 24);
      chk("rd_wiper", d, rd);
      chk("oe_low", 8'h01, {7'h00, oe_low});
    end
  endtask : set_all

  task automatic step(input logic [7:0] start, input logic [3:0] dirs);
    p = 2'($random(seed));
    send(hd, 4'hA, 2'h0, p, start, 24);
    wip[p] = start;
    send(hd, 4'h2, 2'h0, p, {dirs, 4'h0}, 20);
    for (int i = 3; i >= 0; i--) begin
      if (dirs[i]) wip[p] = (wip[p] < 255) ? wip[p] + 1 : 255;
      else wip[p] = (wip[p] > 0) ? wip[p] - 1 : 0;
    end
    chk_wipers();
  endtask : step

  initial begin
    seed = 32'haefe3717;
    rst = 1'b1;
    addr = 2'($random(seed));
    hd = {4'h5, 2'h0, addr};
    bad_count = 0;
    total_checks = 0;
    foreach (wip[i]) wip[i] = 0;
    foreach (slt[i]) slt[i] = 0;
    repeat (16) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    chk_wipers();
    chk("oe_n", 8'h01, {7'h00, so_oe_n});
    set_all();
    chk_wipers();
    for (int k = 0; k < 2; k++) begin
      p = 2'($random(seed));
      r = 2'($random(seed));
      d = 8'($random(seed));
      send(hd, 4'hC, r, p, d, 24);
      slt[p * 4 + r] = d;
      send(hd, 4'h5, 2'h0, 2'h1, 8'h00, 24);
      chk("status", 8'h01, rd);
      chk("oe_low", 8'h01, {7'h00, oe_low});
      wait_idle();
      send(hd, 4'hB, r, p, 8'h00, 24);
      chk("rd_slot", d, rd);
      send(hd, 4'hD, r, p, 8'h00, 16);
      wip[p] = d;
      chk_wipers();
      p = 2'($random(seed));
      r = 2'($random(seed));
      send(hd, 4'hE, r, p, 8'h00, 16);
      slt[p * 4 + r] = wip[p];
      wait_idle();
      send(hd, 4'hB, r, p, 8'h00, 24);
      chk("rd_slot", slt[p * 4 + r][7:0], rd);
    end
    r = 2'($random(seed));
    send(hd, 4'h8, r, 2'h0, 8'h00, 16);
    foreach (wip[i]) slt[i * 4 + r] = wip[i];
    wait_idle();
    send(hd, 4'h5, 2'h0, 2'h1, 8'h00, 24);
    chk("status", 8'h00, rd);
    set_all();
    send(hd, 4'h1, r, 2'h0, 8'h00, 16);
    foreach (wip[i]) wip[i] = slt[i * 4 + r];
    chk_wipers();
    step(8'hFE, 4'b1110);
    step(8'h01, 4'b0001);
    send({4'h6, 2'h0, addr}, 4'hA, 2'h0, 2'h0, 8'h5A, 24);
    send({4'h5, 2'h0, ~addr}, 4'hA, 2'h0, 2'h1, 8'h5A, 24);
    send({4'h5, 2'h1, addr}, 4'hA, 2'h0, 2'h2, 8'h5A, 24);
    send(hd, 4'hF, 2'h0, 2'h2, 8'h5A, 24);
    send(hd, 4'hA, 2'h1, 2'h3, 8'h5A, 24);
    chk_wipers();
    print_verdict();
  end

  initial begin
    repeat (60000) @(posedge clock);
    bad_count++;
    print_verdict();
  end
endmodule : quad_pot_spi_command_decoder_tb_top
